// ### dv/rhsc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// port relations of the counter block
// --------------------------------------
module rhsc_assertions
    import rhsc_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        fast_input_b,
    input wire logic [1:0]  direct_output,
    input wire logic [1:0]  program_output,
    input wire logic        gen_output,
    input wire logic        quad_direction_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // read address phase taken at this edge
    logic rd_req;
    assign rd_req = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_hold; !rd_req |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; rd_req && haddr > 32'h2c |=> hrdata == WORD_ZERO;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
    property p_rel; $fell(sys_rst) |-> !direct_output && !program_output
        && !gen_output && !quad_direction_flag; endproperty
    a_rel: assert property (p_rel) else $error("outputs not clear");
    // scan copy may only take the direct value of the cycle before
    property p_copy; $changed(program_output) |->
        program_output == $past(direct_output); endproperty
    a_copy: assert property (p_copy) else $error("bad scan copy");
    property p_follow; $rose(direct_output[0]) |->
        ##[1:22] (program_output[0] || !direct_output[0]); endproperty
    a_follow: assert property (p_follow) else $error("scan late");
    // phase b level at the a rise decides the direction
    property p_qdir; $changed(quad_direction_flag) |->
        quad_direction_flag == $past(fast_input_b, 2); endproperty
    a_qdir: assert property (p_qdir) else $error("bad direction");
endmodule : rhsc_assertions

bind rhsc_counter rhsc_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fast_input_b(fast_input_b),
    .direct_output(direct_output), .program_output(program_output),
    .gen_output(gen_output), .quad_direction_flag(quad_direction_flag));
`default_nettype wire

// ### dv/rhsc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// quadrature encoder model
// --------------------------------------
module rhsc_pulse_src (
    input  wire logic clk,
    output logic      a,
    output logic      b
);
    initial begin
        a = 1'b0;
        b = 1'b0;
    end
    // one step: four phases of three clocks, equal width, 90 degrees
    // apart; slow enough that the edge detector never misses one
    task automatic step(input logic up);
        for (int i = 0; i < 4; i++) begin
            if ((i[0] == 1'b0) == up)
                a <= ~i[1];
            else
                b <= ~i[1];
            repeat (3) @(posedge clk);
        end
    endtask : step
endmodule : rhsc_pulse_src
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    n_mismatch++; $display("Error %0t: value mismatch", $time); end end
module testbench
    import rhsc_pkg::*;
;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0, hsel = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = WORD_ZERO;
    logic        count_pulse = 1'b0;
    logic        power_restored = 1'b0;
    logic [31:0] hrdata, d;
    logic        hreadyout, hresp, gen_output, quad_direction_flag;
    logic        fast_input_a, fast_input_b;
    logic [1:0]  direct_output, program_output;
    int          n_mismatch = 0, compares = 0, cycles = 0;
    // 200 mhz clock
    always #2.5 clk = ~clk;
    rhsc_pulse_src src (.clk(clk), .a(fast_input_a), .b(fast_input_b));
    // short scan and millisecond counts keep the run brief
    rhsc_counter #(.SCAN_PERIOD(20), .MS_PERIOD(40)) dut (.clk(clk),
        .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .fast_input_a(fast_input_a),
        .fast_input_b(fast_input_b), .count_pulse(count_pulse),
        .power_restored(power_restored), .direct_output(direct_output),
        .program_output(program_output), .gen_output(gen_output),
        .quad_direction_flag(quad_direction_flag));
    // single word transfer; two idle edges let a write take effect
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd);
        haddr  <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsel   <= 1'b1;
        hsize  <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        d = hrdata;
        repeat (2) @(posedge clk);
    endtask : xfer
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, WORD_ZERO);
        `CHK(d, e)
    endtask : rc
    task automatic results;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rc(A_CTRL, 32'h00000100);
        rc(A_MODE, 32'h00010577);
        rc(8'h30, WORD_ZERO);
        // mode 7: count stops at the preset
        xfer(1'b1, A_PRESET0, 32'h00000003);
        xfer(1'b1, A_CTRL, 32'h00000101);
        repeat (4) src.step(1'b1);
        rc(A_CUR0, 32'h00000003);
        `CHK(direct_output[0], 1'b1)
        xfer(1'b1, A_CTRL, 32'h00000105);
        rc(A_CUR0, WORD_ZERO);
        `CHK(direct_output[0], 1'b0)
        // mode 9: up, reset, then down past zero
        xfer(1'b1, A_CTRL, 32'h00000101);
        xfer(1'b1, A_MODE, 32'h00010579);
        repeat (5) src.step(1'b1);
        rc(A_CUR0, 32'h00000005);
        `CHK(direct_output[0], 1'b1)
        `CHK(quad_direction_flag, 1'b0)
        xfer(1'b1, A_CTRL, 32'h00000105);
        rc(A_CUR0, WORD_ZERO);
        `CHK(direct_output[0], 1'b0)
        xfer(1'b1, A_CTRL, 32'h00000101);
        repeat (2) src.step(1'b1);
        repeat (4) src.step(1'b0);
        rc(A_CUR0, WORD_ZERO);
        `CHK(quad_direction_flag, 1'b1)
        // mode 8 on channel 1: on level 2, off level 1
        xfer(1'b1, A_MODE, 32'h00010587);
        xfer(1'b1, A_PRESET1, 32'h00000002);
        xfer(1'b1, A_OFF1, 32'h00000001);
        xfer(1'b1, A_CTRL, 32'h00000103);
        repeat (8) src.step(1'b1);
        `CHK(direct_output[1], 1'b1)
        repeat (100) @(posedge clk);
        `CHK(direct_output[1], 1'b0)
        // mode 6: kept over power loss and run/stop at index 01, cleared by power loss at index 20
        xfer(1'b1, A_MODE, 32'h00010687);
        xfer(1'b1, A_GPRESET, 32'h00000002);
        xfer(1'b1, A_CTRL, 32'h000001a0);
        for (int i = 0; i < 6; i++) begin
            count_pulse <= ~i[0];
            repeat (3) @(posedge clk);
        end
        rc(A_GCUR, 32'h00000003);
        `CHK(gen_output, 1'b1)
        for (int i = 0; i < 2; i++) begin
            power_restored <= 1'b1;
            @(posedge clk);
            power_restored <= 1'b0;
            xfer(1'b1, A_CTRL, 32'h000000a0);
            rc(A_GCUR, i ? WORD_ZERO : 32'h00000003);
            xfer(1'b1, A_MODE, 32'h00200687);
        end
        results();
    end
endmodule : testbench
`default_nettype wire

// ### verilog/rhsc_counter.sv
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - mode 6 compares like 5, survives power loss
// - output on while value at or above preset
// - power retention only for instances 01 to 1f
// - keep setting preserves value over run/stop in mode 6
// - two fast inputs, own counter each in modes 7-8; mode 9 uses both on channel 0
// - mode 7 counts, stops and outputs at preset
// - mode 7 reset clears value and output
// - direct output immediate, program output per scan
// - mode 8 output on when window count >= on
// - mode 8 off below off level, else hold
// - mode 9 counts phase a/b quadrature pair
// - mode 9 range 0 to 999999, output at preset
// - mode 9 reset clears value and output
// - direction flag low when a leads, high lags
module rhsc_counter
    import rhsc_pkg::*;
#(
    parameter longint SCAN_PERIOD = SCAN_CYCLES,
    parameter longint MS_PERIOD   = MS_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        fast_input_a,
    input  wire logic        fast_input_b,
    input  wire logic        count_pulse,
    input  wire logic        power_restored,
    output logic [1:0]       direct_output,
    output logic [1:0]       program_output,
    output logic             gen_output,
    output logic             quad_direction_flag
);
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cur;
        logic [CNT_W-1:0] win;
        logic             dout;
    } rhsc_ch_t;

    typedef struct packed {
        logic [31:0]       hrdata;
        logic              hreadyout;
        logic              hresp;
        logic              wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [CTRL_W-1:0] ctrl;
        logic [MODE_W-1:0] mode0;
        logic [MODE_W-1:0] mode1;
        logic [MODE_W-1:0] gmode;
        logic [IDX_W-1:0]  gidx;
        logic [CNT_W-1:0]  preset0;
        logic [CNT_W-1:0]  off0;
        logic [CNT_W-1:0]  preset1;
        logic [CNT_W-1:0]  off1;
        logic [CNT_W-1:0]  gpreset;
        logic [WIN_W-1:0]  window;
        logic [WIN_W-1:0]  ms_cnt;
        rhsc_ch_t          ch0;
        rhsc_ch_t          ch1;
        logic [CNT_W-1:0]  gcur;
        logic              gout;
        logic              pout0;
        logic              pout1;
        logic              qdir;
        logic              gpulse_q;
        logic              run_q;
    } rhsc_state_t;

    rhsc_state_t st;
    rhsc_state_t next_st;

    logic scan_tick;
    logic ms_tick;

    rhsc_fe_if fe ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v >= CUR_MAX) ? CUR_MAX : v + CUR_ONE;
    endfunction : sat_inc

    // one high-speed channel; mode 9 quadrature only runs on channel 0
    function automatic rhsc_ch_t hs_step(
        input rhsc_ch_t          c,
        input logic [MODE_W-1:0] mode,
        input logic [CNT_W-1:0]  preset,
        input logic [CNT_W-1:0]  offp,
        input logic              en,
        input logic              rst,
        input logic              edge_in,
        input logic              wtick,
        input logic              qstep,
        input logic              qup
    );
        rhsc_ch_t         n;
        logic [CNT_W-1:0] w;
        n = c;
        w = c.win;
        case (mode)
            MODE_HS_STOP: begin
                if (rst) begin
                    n.cur  = CUR_ZERO;
                    n.dout = 1'b0;
                end else begin
                    if (en && edge_in && c.cur < preset) begin
                        n.cur = c.cur + CUR_ONE;
                    end
                    n.dout = (n.cur >= preset);
                end
            end
            MODE_HS_FREQ: begin
                if (rst) begin
                    n.cur  = CUR_ZERO;
                    n.win  = CUR_ZERO;
                    n.dout = 1'b0;
                end else begin
                    if (en && edge_in) begin
                        w = sat_inc(c.win);
                    end
                    n.win = w;
                    if (wtick) begin
                        n.cur = w;
                        n.win = CUR_ZERO;
                        if (w >= preset) begin
                            n.dout = 1'b1;
                        end else if (w < offp) begin
                            n.dout = 1'b0;
                        end
                    end
                end
            end
            MODE_HS_QUAD: begin
                if (rst) begin
                    n.cur  = CUR_ZERO;
                    n.dout = 1'b0;
                end else begin
                    if (en && qstep) begin
                        if (qup) begin
                            n.cur = sat_inc(c.cur);
                        end else if (c.cur != CUR_ZERO) begin
                            n.cur = c.cur - CUR_ONE;
                        end
                    end
                    n.dout = (n.cur >= preset);
                end
            end
            default: begin
                n = c;
            end
        endcase
        hs_step = n;
    endfunction : hs_step

    // ------------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------------
    rhsc_front_end u_front_end (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .fast_input_a (fast_input_a),
        .fast_input_b (fast_input_b),
        .fe           (fe.src)
    );

    rhsc_tick_gen #(.W(TICK_W)) u_scan_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .period  (TICK_W'(SCAN_PERIOD)),
        .tick    (scan_tick)
    );

    rhsc_tick_gen #(.W(TICK_W)) u_ms_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .period  (TICK_W'(MS_PERIOD)),
        .tick    (ms_tick)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        addr_ok;
        logic        wtick;
        logic        gedge;
        logic        run_chg;
        logic        retain_pf;
        logic        retain_rs;
        logic        quad;
        logic [31:0] rd;
        addr_ok   = 1'b0;
        wtick     = 1'b0;
        gedge     = 1'b0;
        run_chg   = 1'b0;
        retain_pf = 1'b0;
        retain_rs = 1'b0;
        quad      = 1'b0;
        rd        = WORD_ZERO;
        next_st   = st;

        // bus: zero wait states, read data registered into data phase
        addr_ok           = hsel && hready && (htrans == HTRANS_NONSEQ);
        next_st.hreadyout = 1'b1;
        next_st.hresp     = 1'b0;
        next_st.wr_pend   = addr_ok && hwrite;
        next_st.wr_addr   = haddr[ADDR_W-1:0];
        case (haddr[ADDR_W-1:0])
            A_CTRL:    rd = 32'(st.ctrl);
            A_MODE:    rd = 32'(st.mode0) << M_CH0_LO
                          | 32'(st.mode1) << M_CH1_LO
                          | 32'(st.gmode) << M_GEN_LO
                          | 32'(st.gidx)  << M_IDX_LO;
            A_PRESET0: rd = 32'(st.preset0);
            A_OFF0:    rd = 32'(st.off0);
            A_PRESET1: rd = 32'(st.preset1);
            A_OFF1:    rd = 32'(st.off1);
            A_GPRESET: rd = 32'(st.gpreset);
            A_WINDOW:  rd = 32'(st.window);
            A_CUR0:    rd = 32'(st.ch0.cur);
            A_CUR1:    rd = 32'(st.ch1.cur);
            A_GCUR:    rd = 32'(st.gcur);
            A_STATUS:  rd = 32'(st.ch0.dout) << S_DOUT0
                          | 32'(st.ch1.dout) << S_DOUT1
                          | 32'(st.pout0)    << S_POUT0
                          | 32'(st.pout1)    << S_POUT1
                          | 32'(st.gout)     << S_GOUT
                          | 32'(st.qdir)     << S_QDIR;
            default:   rd = WORD_ZERO;
        endcase
        if (addr_ok && !hwrite) begin
            next_st.hrdata = rd;
        end

        // register writes land in the data phase
        if (st.wr_pend) begin
            case (st.wr_addr)
                A_CTRL:    next_st.ctrl    = hwdata[CTRL_W-1:0];
                A_MODE: begin
                    next_st.mode0 = hwdata[M_CH0_LO +: MODE_W];
                    next_st.mode1 = hwdata[M_CH1_LO +: MODE_W];
                    next_st.gmode = hwdata[M_GEN_LO +: MODE_W];
                    next_st.gidx  = hwdata[M_IDX_LO +: IDX_W];
                end
                A_PRESET0: next_st.preset0 = hwdata[CNT_W-1:0];
                A_OFF0:    next_st.off0    = hwdata[CNT_W-1:0];
                A_PRESET1: next_st.preset1 = hwdata[CNT_W-1:0];
                A_OFF1:    next_st.off1    = hwdata[CNT_W-1:0];
                A_GPRESET: next_st.gpreset = hwdata[CNT_W-1:0];
                A_WINDOW:  next_st.window  = hwdata[WIN_W-1:0];
                default:   next_st.ctrl    = st.ctrl;
            endcase
        end

        // interval window in milliseconds, zero treated as one
        if (ms_tick) begin
            if (st.ms_cnt + WIN_ONE >= st.window) begin
                next_st.ms_cnt = WIN_ZERO;
                wtick          = 1'b1;
            end else begin
                next_st.ms_cnt = st.ms_cnt + WIN_ONE;
            end
        end

        // high-speed channels: a on channel 0, b on channel 1
        quad = (st.mode0 == MODE_HS_QUAD);
        next_st.ch0 = hs_step(st.ch0, st.mode0, st.preset0, st.off0,
                              st.ctrl[C_EN0], st.ctrl[C_RST0], fe.rise_a,
                              wtick, fe.qstep, fe.qup);
        next_st.ch1 = hs_step(st.ch1, quad ? MODE_CMP : st.mode1,
                              st.preset1, st.off1, st.ctrl[C_EN1],
                              st.ctrl[C_RST1], fe.rise_b, wtick,
                              1'b0, 1'b0);
        if (quad && fe.qstep) begin
            next_st.qdir = ~fe.qup;
        end

        // program copy of the direct outputs only moves once per scan
        if (scan_tick) begin
            next_st.pout0 = st.ch0.dout;
            next_st.pout1 = st.ch1.dout;
        end

        // general comparison counter, overflow wraps and keeps counting
        gedge     = count_pulse & ~st.gpulse_q;
        run_chg   = st.ctrl[C_RUN] ^ st.run_q;
        retain_pf = (st.gmode == MODE_CMP_KEEP)
                 && (st.gidx >= IDX_FIRST) && (st.gidx <= IDX_LAST);
        retain_rs = (st.gmode == MODE_CMP_KEEP) && st.ctrl[C_KEEP];
        next_st.gpulse_q = count_pulse;
        next_st.run_q    = st.ctrl[C_RUN];
        if (st.ctrl[C_GRST]) begin
            next_st.gcur = CUR_ZERO;
        end else if (power_restored && !retain_pf) begin
            next_st.gcur = CUR_ZERO;
        end else if (run_chg && !retain_rs) begin
            next_st.gcur = CUR_ZERO;
        end else if (st.ctrl[C_RUN] && st.ctrl[C_GEN] && gedge
                     && (st.gmode == MODE_CMP
                      || st.gmode == MODE_CMP_KEEP)) begin
            if (st.ctrl[C_GDOWN]) begin
                next_st.gcur = st.gcur - CUR_ONE;
            end else begin
                next_st.gcur = st.gcur + CUR_ONE;
            end
        end
        next_st.gout = (next_st.gcur >= st.gpreset);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st           <= '0;
            st.hreadyout <= 1'b1;
            st.ctrl      <= CTRL_RST;
            st.run_q     <= CTRL_RST[C_RUN];
            st.mode0     <= MODE_CH0_RST;
            st.mode1     <= MODE_CH1_RST;
            st.gmode     <= MODE_GEN_RST;
            st.gidx      <= IDX_RST;
            st.window    <= WIN_ONE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign hrdata              = st.hrdata;
    assign hreadyout           = st.hreadyout;
    assign hresp               = st.hresp;
    assign direct_output       = {st.ch1.dout, st.ch0.dout};
    assign program_output      = {st.pout1, st.pout0};
    assign gen_output          = st.gout;
    assign quad_direction_flag = st.qdir;
endmodule : rhsc_counter
`default_nettype wire

// ### verilog/rhsc_fe_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rhsc_fe_if;
    logic rise_a;   // rising edge seen on fast_input_a
    logic rise_b;   // rising edge seen on fast_input_b
    logic qstep;    // one quadrature step
    logic qup;      // step direction, 1 while phase a leads
    modport src (output rise_a, output rise_b, output qstep, output qup);
    modport dst (input rise_a, input rise_b, input qstep, input qup);
endinterface : rhsc_fe_if
`default_nettype wire

// ### verilog/rhsc_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module rhsc_front_end (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic fast_input_a,
    input  wire logic fast_input_b,
    rhsc_fe_if.src    fe
);
    typedef struct packed {
        logic a_q;
        logic b_q;
        logic rise_a;
        logic rise_b;
        logic qstep;
        logic qup;
    } rhsc_fe_t;

    rhsc_fe_t st;
    rhsc_fe_t next_st;

    // ------------------------------------------------------------------
    // edge and quadrature decode
    // ------------------------------------------------------------------
    // x1 decode on phase a rising: b low there means a leads b
    always_comb begin
        next_st        = st;
        next_st.a_q    = fast_input_a;
        next_st.b_q    = fast_input_b;
        next_st.rise_a = fast_input_a & ~st.a_q;
        next_st.rise_b = fast_input_b & ~st.b_q;
        next_st.qstep  = fast_input_a & ~st.a_q;
        next_st.qup    = ~fast_input_b;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fe.rise_a = st.rise_a;
    assign fe.rise_b = st.rise_b;
    assign fe.qstep  = st.qstep;
    assign fe.qup    = st.qup;
endmodule : rhsc_front_end
`default_nettype wire

// ### verilog/rhsc_pkg.sv
`default_nettype none
package rhsc_pkg;
    // ------------------------------------------------------------------
    // widths and counting range
    // ------------------------------------------------------------------
    localparam int            CNT_W    = 20;
    localparam logic [19:0]   CUR_ZERO = 20'h00000;
    localparam logic [19:0]   CUR_ONE  = 20'h00001;
    localparam logic [19:0]   CUR_MAX  = 20'hf423f;   // 999999
    localparam int            MODE_W   = 4;
    localparam logic [3:0]    MODE_CMP      = 4'h5;
    localparam logic [3:0]    MODE_CMP_KEEP = 4'h6;
    localparam logic [3:0]    MODE_HS_STOP  = 4'h7;
    localparam logic [3:0]    MODE_HS_FREQ  = 4'h8;
    localparam logic [3:0]    MODE_HS_QUAD  = 4'h9;
    localparam int            IDX_W     = 8;
    localparam logic [7:0]    IDX_FIRST = 8'h01;
    localparam logic [7:0]    IDX_LAST  = 8'h1f;
    localparam int            WIN_W     = 16;
    localparam logic [15:0]   WIN_ONE   = 16'h0001;
    localparam logic [15:0]   WIN_ZERO  = 16'h0000;

    // ------------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_MODE     = 8'h04;
    localparam logic [7:0]  A_PRESET0  = 8'h08;
    localparam logic [7:0]  A_OFF0     = 8'h0c;
    localparam logic [7:0]  A_PRESET1  = 8'h10;
    localparam logic [7:0]  A_OFF1     = 8'h14;
    localparam logic [7:0]  A_GPRESET  = 8'h18;
    localparam logic [7:0]  A_WINDOW   = 8'h1c;
    localparam logic [7:0]  A_CUR0     = 8'h20;
    localparam logic [7:0]  A_CUR1     = 8'h24;
    localparam logic [7:0]  A_GCUR     = 8'h28;
    localparam logic [7:0]  A_STATUS   = 8'h2c;

    // control register fields
    localparam int C_EN0   = 0;
    localparam int C_EN1   = 1;
    localparam int C_RST0  = 2;
    localparam int C_RST1  = 3;
    localparam int C_GRST  = 4;
    localparam int C_GEN   = 5;
    localparam int C_GDOWN = 6;
    localparam int C_KEEP  = 7;
    localparam int C_RUN   = 8;
    localparam int CTRL_W  = 9;
    localparam logic [8:0] CTRL_RST = 9'h100;   // run after reset

    // mode register fields
    localparam int M_CH0_LO = 0;
    localparam int M_CH1_LO = 4;
    localparam int M_GEN_LO = 8;
    localparam int M_IDX_LO = 16;
    localparam logic [3:0] MODE_CH0_RST = 4'h7;
    localparam logic [3:0] MODE_CH1_RST = 4'h7;
    localparam logic [3:0] MODE_GEN_RST = 4'h5;
    localparam logic [7:0] IDX_RST      = 8'h01;

    // status register fields
    localparam int S_DOUT0 = 0;
    localparam int S_DOUT1 = 1;
    localparam int S_POUT0 = 2;
    localparam int S_POUT1 = 3;
    localparam int S_GOUT  = 4;
    localparam int S_QDIR  = 5;

    // ahb-lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] WORD_ZERO     = 32'h00000000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint CLK_PERIOD_PS = 5000;
    localparam longint MS_TIME_NS    = 1000000;
    localparam longint SCAN_TIME_NS  = 1000000;
    localparam longint MS_CYCLES     = (MS_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam longint SCAN_CYCLES   = (SCAN_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int     TICK_W        = 24;
    localparam int     FAST_MAX_HZ   = 1000;   // pulse-source limit
endpackage : rhsc_pkg
`default_nettype wire

// ### verilog/rhsc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rhsc_tick_gen #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] period,
    output logic              tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } rhsc_tick_t;

    rhsc_tick_t st;
    rhsc_tick_t next_st;

    // ------------------------------------------------------------------
    // free running divider, one-cycle tick per period
    // ------------------------------------------------------------------
    // period of zero behaves as one so the tick never stalls
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.cnt + W'(1) >= period) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : rhsc_tick_gen
`default_nettype wire
